// ===== hdl/dnc_bank.sv
// Oscillator selection, frame reset policy and gain configuration bank
`include "dnc_consts.svh"
`default_nettype none
module dnc_bank (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     reg_wr_en,
  input  wire logic                     reg_rd_en,
  input  wire logic [11:0]              reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  output logic                          reg_rdata_valid,
  input  wire logic [15:0]              osc1_freq_word,
  input  wire logic [15:0]              osc2_freq_word,
  input  wire logic [7:0]               conv1_osc3_lower_byte,
  input  wire logic                     dual_band_en,
  input  wire logic                     high_bw_path,
  input  wire logic [1:0]               osc_gpio_pins,
  input  wire logic                     frame_reset_evt,
  input  wire logic                     conv_start,
  input  wire logic                     clk_div_resync,
  input  wire logic signed [15:0]       conv1_sample,
  output logic      [15:0]              conv1_active_freq,
  output dnc_pkg::dnc_osc_e             conv1_active_osc,
  output logic      [15:0]              conv2_freq,
  output logic                          conv2_freq_valid,
  output logic                          conv_reset,
  output logic signed [15:0]            conv1_sample_out
);
  import dnc_pkg::*;

  logic [7:0]     conv1_osc3_upper_byte_q;
  logic [7:0]     conv2_osc4_lower_byte_q;
  logic [7:0]     conv2_osc4_upper_byte_q;
  logic           osc_choice_from_pins_q;
  logic [1:0]     osc_choice_code_q;
  logic [1:0]     frame_clock_reset_policy_q;
  logic           conv1_double_gain_q;
  logic [1:0]     pins_meta_q;
  logic [1:0]     pins_sync_q;
  logic [2:0]     evt_meta_q;
  logic [2:0]     evt_sync_q;
  logic           frame_evt;
  logic           start_evt;
  logic           resync_evt;
  logic           resync_pend_q;
  dnc_rst_state_e rst_state_q;
  dnc_osc_e       sel_osc;
  logic [15:0]    sel_freq;

  function automatic logic [15:0] dnc_join(input logic [7:0] hi,
                                           input logic [7:0] lo);
    dnc_join = {hi, lo};
  endfunction : dnc_join

  // Register writes; upper unused bits are not stored, so they read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv1_osc3_upper_byte_q    <= `DNC_RESET_BYTE;
      conv2_osc4_lower_byte_q    <= `DNC_RESET_BYTE;
      conv2_osc4_upper_byte_q    <= `DNC_RESET_BYTE;
      osc_choice_from_pins_q     <= 1'b0;
      osc_choice_code_q          <= 2'b00;
      frame_clock_reset_policy_q <= 2'b00;
      conv1_double_gain_q        <= 1'b0;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `DNC_ADDR_OSC3_UPPER: conv1_osc3_upper_byte_q <= reg_wdata;
        `DNC_ADDR_OSC4_LOWER: conv2_osc4_lower_byte_q <= reg_wdata;
        `DNC_ADDR_OSC4_UPPER: conv2_osc4_upper_byte_q <= reg_wdata;
        `DNC_ADDR_PIN_SEL:    osc_choice_from_pins_q  <= reg_wdata[0];
        `DNC_ADDR_OSC_SEL:    osc_choice_code_q       <= reg_wdata[1:0];
        `DNC_ADDR_RST_POLICY: frame_clock_reset_policy_q <= reg_wdata[1:0];
        `DNC_ADDR_GAIN_BOOST: conv1_double_gain_q     <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // Read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd_en;
      if (reg_rd_en) begin
        unique case (reg_addr)
          `DNC_ADDR_OSC3_UPPER: reg_rdata <= conv1_osc3_upper_byte_q;
          `DNC_ADDR_OSC4_LOWER: reg_rdata <= conv2_osc4_lower_byte_q;
          `DNC_ADDR_OSC4_UPPER: reg_rdata <= conv2_osc4_upper_byte_q;
          `DNC_ADDR_PIN_SEL:    reg_rdata <= {7'h00, osc_choice_from_pins_q};
          `DNC_ADDR_OSC_SEL:    reg_rdata <= {6'h00, osc_choice_code_q};
          `DNC_ADDR_RST_POLICY:
            reg_rdata <= {6'h00, frame_clock_reset_policy_q};
          `DNC_ADDR_GAIN_BOOST: reg_rdata <= {7'h00, conv1_double_gain_q};
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Pins and event strobes come from outside the clock domain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pins_meta_q <= 2'b00;
      pins_sync_q <= 2'b00;
      evt_meta_q  <= 3'b000;
      evt_sync_q  <= 3'b000;
    end else begin
      pins_meta_q <= osc_gpio_pins;
      pins_sync_q <= pins_meta_q;
      evt_meta_q  <= {clk_div_resync, conv_start, frame_reset_evt};
      evt_sync_q  <= evt_meta_q;
    end
  end

  assign frame_evt  = evt_sync_q[0];
  assign start_evt  = evt_sync_q[1];
  assign resync_evt = evt_sync_q[2];

  // Oscillator choice; code 11 is undefined and falls back to oscillator 1
  always_comb begin
    sel_osc = osc_choice_from_pins_q ? dnc_osc_e'(pins_sync_q)
                                     : dnc_osc_e'(osc_choice_code_q);
    unique case (sel_osc)
      DNC_OSC1: sel_freq = osc1_freq_word;
      DNC_OSC2: sel_freq = osc2_freq_word;
      DNC_OSC3: sel_freq = dnc_join(conv1_osc3_upper_byte_q,
                                    conv1_osc3_lower_byte);
      default: begin
        sel_freq = osc1_freq_word;
        sel_osc  = DNC_OSC1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv1_active_freq <= 16'h0000;
      conv1_active_osc  <= DNC_OSC1;
      conv2_freq        <= 16'h0000;
      conv2_freq_valid  <= 1'b0;
    end else begin
      conv1_active_freq <= sel_freq;
      conv1_active_osc  <= sel_osc;
      // Band two word only matters in dual-band operation
      conv2_freq <= dual_band_en ?
                    dnc_join(conv2_osc4_upper_byte_q,
                             conv2_osc4_lower_byte_q) : 16'h0000;
      conv2_freq_valid <= dual_band_en;
    end
  end

  // Frame reset policy: armed after start, one reset, then per policy
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_state_q   <= DNC_ARMED;
      resync_pend_q <= 1'b0;
      conv_reset    <= 1'b0;
    end else begin
      conv_reset <= 1'b0;
      if (resync_evt) begin
        resync_pend_q <= 1'b1;
      end
      unique case (dnc_policy_e'(frame_clock_reset_policy_q))
        DNC_POL_EVERY: begin
          conv_reset  <= frame_evt;
          rst_state_q <= DNC_ARMED;
        end
        DNC_POL_START_ONLY: begin
          // Frame resets ignored; latency then not deterministic
          conv_reset  <= start_evt;
          rst_state_q <= DNC_ARMED;
        end
        default: begin
          if (start_evt) begin
            rst_state_q   <= DNC_ARMED;
            resync_pend_q <= 1'b0;
          end else if (frame_evt) begin
            unique case (rst_state_q)
              DNC_ARMED: begin
                conv_reset  <= 1'b1;
                rst_state_q <= DNC_RUNNING;
              end
              DNC_RUNNING: begin
                if (resync_pend_q) begin
                  conv_reset    <= 1'b1;
                  resync_pend_q <= resync_evt;
                  if (frame_clock_reset_policy_q == 2'b10) begin
                    rst_state_q <= DNC_SECOND;
                  end
                end
              end
              DNC_SECOND: begin
                conv_reset  <= 1'b1;
                rst_state_q <= DNC_RUNNING;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Doubling saturates; suppressed on the high-bandwidth filter path
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv1_sample_out <= 16'sh0000;
    end else if (conv1_double_gain_q && !high_bw_path) begin
      if (conv1_sample[15] != conv1_sample[14]) begin
        conv1_sample_out <= conv1_sample[15] ? 16'sh8000 : 16'sh7FFF;
      end else begin
        conv1_sample_out <= {conv1_sample[14:0], 1'b0};
      end
    end else begin
      conv1_sample_out <= conv1_sample;
    end
  end
endmodule : dnc_bank
`default_nettype wire

// ===== hdl/dnc_consts.svh
// Offsets, reset values and widths for the oscillator select bank
`ifndef DNC_CONSTS_SVH
`define DNC_CONSTS_SVH
`define DNC_ADDR_OSC3_UPPER   12'h00C
`define DNC_ADDR_OSC4_LOWER   12'h00D
`define DNC_ADDR_OSC4_UPPER   12'h00E
`define DNC_ADDR_PIN_SEL      12'h00F
`define DNC_ADDR_OSC_SEL      12'h010
`define DNC_ADDR_RST_POLICY   12'h011
`define DNC_ADDR_GAIN_BOOST   12'h014
`define DNC_RESET_BYTE        8'h00
`define DNC_FREQ_W            16
`define DNC_SAMPLE_W          16
`endif

// ===== hdl/dnc_pkg.sv
// Types shared by the oscillator select bank
`default_nettype none
package dnc_pkg;
  typedef enum logic [1:0] {
    DNC_POL_EVERY,
    DNC_POL_FIRST_RESYNC,
    DNC_POL_FIRST_TWO,
    DNC_POL_START_ONLY
  } dnc_policy_e;
  typedef enum logic [1:0] {
    DNC_OSC1,
    DNC_OSC2,
    DNC_OSC3,
    DNC_OSC_BAD
  } dnc_osc_e;
  typedef enum {
    DNC_ARMED,
    DNC_RUNNING,
    DNC_SECOND
  } dnc_rst_state_e;
endpackage : dnc_pkg
`default_nettype wire

// ===== testbench/dnc_bank_props.sv
// Port-level assertions for the oscillator select bank
`default_nettype none
module dnc_bank_props (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               reg_rd_en,
  input wire logic               reg_rdata_valid,
  input wire logic               dual_band_en,
  input wire logic               high_bw_path,
  input wire logic               frame_reset_evt,
  input wire logic               conv_start,
  input wire logic signed [15:0] conv1_sample,
  input wire dnc_pkg::dnc_osc_e  conv1_active_osc,
  input wire logic [15:0]        conv2_freq,
  input wire logic               conv2_freq_valid,
  input wire logic               conv_reset,
  input wire logic signed [15:0] conv1_sample_out
);
  import dnc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_rd_answer: assert property (reg_rd_en |=> reg_rdata_valid)
    else $error("read strobe not answered");
  chk_rd_quiet: assert property (!reg_rd_en |=> !reg_rdata_valid)
    else $error("read valid without strobe");
  // Sync adds two cycles, so any converter reset traces back three
  chk_reset_cause: assert property (conv_reset |->
    $past(frame_reset_evt, 3) || $past(conv_start, 3))
    else $error("converter reset without cause");
  chk_osc_legal: assert property (conv1_active_osc != DNC_OSC_BAD)
    else $error("undefined oscillator chosen");
  chk_reset_zero: assert property ($rose(rst_n) |->
    conv1_active_osc == DNC_OSC1 && !conv_reset && conv2_freq == 16'h0000)
    else $error("outputs not cleared by reset");
  chk_band2_off: assert property (!conv2_freq_valid |-> conv2_freq == 0)
    else $error("band two word leaks in single band");
  chk_band2_on: assert property (dual_band_en[*2] |-> conv2_freq_valid)
    else $error("band two not enabled");
  chk_hbw_pass: assert property (high_bw_path |=>
    conv1_sample_out == $past(conv1_sample))
    else $error("gain applied on wide path");
endmodule : dnc_bank_props
bind dnc_bank dnc_bank_props dnc_bank_props_i (.core_clk, .rst_n,
  .reg_rd_en, .reg_rdata_valid, .dual_band_en, .high_bw_path,
  .frame_reset_evt, .conv_start, .conv1_sample, .conv1_active_osc,
  .conv2_freq, .conv2_freq_valid, .conv_reset, .conv1_sample_out);
`default_nettype wire

// ===== testbench/dnc_host_model.sv
// Host model driving the bank's register strobe port
`default_nettype none
module dnc_host_model (
  input wire logic       core_clk,
  output logic           reg_wr_en,
  output logic           reg_rd_en,
  output logic [11:0]    reg_addr,
  output logic [7:0]     reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 12'hFFF;
    reg_wdata = 8'hFF;
  end
  // Released lines carry the inverse so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    // Valid stands for one cycle only, so take the data before releasing
    d = reg_rdata_valid ? reg_rdata : 8'hXX;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : dnc_host_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the oscillator select bank
`include "dnc_consts.svh"
`default_nettype none
module testbench;
  import dnc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, reg_wr_en, reg_rd_en, reg_rdata_valid;
  logic dual_band_en, high_bw_path, conv2_freq_valid, conv_reset;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic [1:0] osc_gpio_pins;
  logic [2:0] ev;
  logic signed [15:0] conv1_sample, conv1_sample_out;
  logic [15:0] conv1_active_freq, conv2_freq;
  dnc_osc_e conv1_active_osc;
  int n_mismatch, checks, cyc;
  localparam logic [11:0] ADR [7] = '{12'h00C, 12'h00D, 12'h00E,
    12'h00F, 12'h010, 12'h011, 12'h014};
  localparam logic [7:0] DAT [7] = '{8'hA5, 8'h5A, 8'hC3, 8'h01, 8'h02,
    8'h03, 8'h01};
  localparam logic [15:0] FW [3] = '{16'h1111, 16'h2222, 16'hA534};
  dnc_bank dnc_bank_i (.core_clk, .rst_n, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rdata_valid,
    .osc1_freq_word(FW[0]), .osc2_freq_word(FW[1]),
    .conv1_osc3_lower_byte(8'h34), .dual_band_en, .high_bw_path,
    .osc_gpio_pins, .frame_reset_evt(ev[0]), .conv_start(ev[1]),
    .clk_div_resync(ev[2]), .conv1_sample, .conv1_active_freq,
    .conv1_active_osc, .conv2_freq, .conv2_freq_valid, .conv_reset,
    .conv1_sample_out);
  dnc_host_model host_i (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rdata_valid);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Generous ceiling: the full sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic rchk(logic [11:0] a, logic [7:0] e);
    host_i.rd(a, got);
    cmp("register", {8'h00, e}, {8'h00, got});
  endtask : rchk
  task automatic wt(int n);
    repeat (n) @(negedge core_clk);
  endtask : wt
  // Pulse event k once and count converter resets that follow
  task automatic evt(int k, int e);
    int n;
    n = 0;
    @(negedge core_clk);
    ev[k] = 1'b1;
    @(negedge core_clk);
    ev = 3'b000;
    repeat (6) begin
      @(negedge core_clk);
      if (conv_reset === 1'b1) n++;
    end
    cmp("conv_reset count", 16'(e), 16'(n));
  endtask : evt
  initial begin
    rst_n = 1'b0;
    ev = 3'b000;
    osc_gpio_pins = 2'h0;
    dual_band_en = 1'b0;
    high_bw_path = 1'b0;
    conv1_sample = 16'h0123;
    wt(3);
    rst_n = 1'b1;
    foreach (ADR[i]) rchk(ADR[i], 8'h00);
    rchk(12'h013, 8'h00);
    foreach (ADR[i]) host_i.wr(ADR[i], DAT[i]);
    foreach (ADR[i]) rchk(ADR[i], DAT[i]);
    $display("test registers finished");
    host_i.wr(`DNC_ADDR_PIN_SEL, 8'h00);
    for (int c = 0; c < 3; c++) begin
      host_i.wr(`DNC_ADDR_OSC_SEL, 8'(c));
      wt(2);
      cmp("osc", 16'(c), 16'(conv1_active_osc));
      cmp("freq", FW[c], conv1_active_freq);
    end
    host_i.wr(`DNC_ADDR_PIN_SEL, 8'h01);
    osc_gpio_pins = 2'h1;
    wt(5);
    cmp("pin freq", FW[1], conv1_active_freq);
    dual_band_en = 1'b1;
    wt(2);
    cmp("band2", 16'hC35A, conv2_freq);
    dual_band_en = 1'b0;
    wt(2);
    cmp("band2 off", 16'h0000, conv2_freq);
    cmp("gain", 16'h0246, conv1_sample_out);
    high_bw_path = 1'b1;
    wt(2);
    cmp("wide path", 16'h0123, conv1_sample_out);
    $display("test selection finished");
    host_i.wr(`DNC_ADDR_RST_POLICY, 8'h00);
    evt(0, 1);
    evt(0, 1);
    host_i.wr(`DNC_ADDR_RST_POLICY, 8'h03);
    evt(0, 0);
    evt(1, 1);
    host_i.wr(`DNC_ADDR_RST_POLICY, 8'h01);
    foreach (ADR[i]) begin
      evt(1, 0);
      evt(0, 1);
      evt(0, 0);
      evt(2, 0);
      evt(0, 1);
      if (i == 1) break;
      host_i.wr(`DNC_ADDR_RST_POLICY, 8'h02);
    end
    evt(0, 1);
    evt(0, 0);
    $display("test policies finished");
    rst_n = 1'b0;
    wt(2);
    rst_n = 1'b1;
    foreach (ADR[i]) rchk(ADR[i], 8'h00);
    $display("test second reset finished");
    summarize();
  end
endmodule : testbench
`default_nettype wire
